// ===== include/flash_cmd_pkg.sv
/*
 * Constants for the host-side command sequencer of a parallel NOR flash.
 * Assumes a 100 MHz clock and an asynchronous flash on the far side of the pins.
 */
// Summary of operation
// - Sequences open with AA to 555 then 55 to 2AA; byte mode uses AAA and 555.
// - Reset is allowed inside autoselect sequences; the host resets to leave autoselect.
// - When the time-limit flag bit rises during program or erase, the host writes reset; flash_cmd_host only raises time_limit_out and waits for a reset op.
// - Program is unlock, A0 to the third unlock address, then value to location.
// - Sector erase is unlock, 80, unlock, then 30 inside the sector.
// - Block erase is the same setup ending with 50 inside the block.
// - Chip erase is the erase setup ending with 10 to the third unlock address.
// - Lone B0 suspends an erase; lone 30 resumes it.
// - Host writes with select and write strobe low, output strobe high.
package flash_cmd_pkg;
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 21'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 21'h0002aa;
   localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 21'h000aaa;
   localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 21'h000555;
   localparam logic [DATA_W-1:0] DAT_UNLOCK1 = 16'h00aa;
   localparam logic [DATA_W-1:0] DAT_UNLOCK2 = 16'h0055;
   localparam logic [DATA_W-1:0] DAT_RESET = 16'h00f0;
   localparam logic [DATA_W-1:0] DAT_AUTOSEL = 16'h0090;
   localparam logic [DATA_W-1:0] DAT_PROGRAM = 16'h00a0;
   localparam logic [DATA_W-1:0] DAT_ERASE_SETUP = 16'h0080;
   localparam logic [DATA_W-1:0] DAT_CHIP_ERASE = 16'h0010;
   localparam logic [DATA_W-1:0] DAT_BLOCK_ERASE = 16'h0050;
   localparam logic [DATA_W-1:0] DAT_SECTOR_ERASE = 16'h0030;
   localparam logic [DATA_W-1:0] DAT_SUSPEND = 16'h00b0;
   localparam logic [DATA_W-1:0] DAT_RESUME = 16'h0030;
   // Autoselect offsets, word then byte
   localparam logic [ADDR_W-1:0] AS_MAKER = 21'h000000;
   localparam logic [ADDR_W-1:0] AS_CONT = 21'h000100;
   localparam logic [ADDR_W-1:0] AS_DEV_WORD = 21'h000001;
   localparam logic [ADDR_W-1:0] AS_DEV_BYTE = 21'h000002;
   localparam logic [ADDR_W-1:0] AS_PROT_WORD = 21'h000002;
   localparam logic [ADDR_W-1:0] AS_PROT_BYTE = 21'h000004;
   localparam int TIME_LIMIT_BIT = 5;
   localparam int STATUS_TOGGLE_BIT = 6;
   // Bus cycle timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SETUP_NS = 30;
   localparam int T_PULSE_NS = 50;
   localparam int T_ACCESS_NS = 70;
   localparam int T_HOLD_NS = 20;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // Host commands
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_PROGRAM = 4'h3,
      OP_CHIP_ERASE = 4'h4, OP_BLOCK_ERASE = 4'h5, OP_SECTOR_ERASE = 4'h6,
      OP_SUSPEND = 4'h7, OP_RESUME = 4'h8
   } op_e;
endpackage : flash_cmd_pkg

// ===== hw/flash_bus_cycle.sv
/*
 * One asynchronous bus cycle on the flash pins: write or read.
 * Assumes the caller pulses start_in for one cycle, then waits for done_out.
 */
`timescale 1ns/1ps
module flash_bus_cycle (
   input  wire logic                                   clk_in,
   input  wire logic                                   reset_in,
   input  wire logic                                   start_in,
   input  wire logic                                   write_in,
   input  wire logic [flash_cmd_pkg::ADDR_W-1:0]       addr_in,
   input  wire logic [flash_cmd_pkg::DATA_W-1:0]       wdata_in,
   input  wire logic [flash_cmd_pkg::DATA_W-1:0]       dq_sync_in,
   output logic                                        done_out,
   output logic [flash_cmd_pkg::DATA_W-1:0]            rdata_out,
   output logic [flash_cmd_pkg::ADDR_W-1:0]            addr_out,
   output logic [flash_cmd_pkg::DATA_W-1:0]            dq_out,
   output logic                                        dq_oe_n_out,
   output logic                                        ce_n_out,
   output logic                                        we_n_out,
   output logic                                        oe_n_out
);
   import flash_cmd_pkg::*;

   typedef enum logic [2:0] {
      BC_IDLE = 3'b000, BC_SETUP = 3'b001, BC_PULSE = 3'b010, BC_ACCESS = 3'b011, BC_HOLD = 3'b100
   } bc_state_e;

   bc_state_e        state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic             write_reg;

   wire cnt_done = (cnt_reg == '0);

   // ******************************
   // Phase sequencing
   // ******************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         BC_IDLE:   if (start_in) state_next = BC_SETUP;
         BC_SETUP:  if (cnt_done) state_next = write_reg ? BC_PULSE : BC_ACCESS;
         BC_PULSE:  if (cnt_done) state_next = BC_HOLD;
         BC_ACCESS: if (cnt_done) state_next = BC_HOLD;
         BC_HOLD:   if (cnt_done) state_next = BC_IDLE;
         default:   state_next = BC_IDLE;
      endcase
   end

   wire [CNT_W-1:0] load_val =
      (state_next == BC_SETUP)  ? CNT_W'(SETUP_CYC - 1) :
      (state_next == BC_PULSE)  ? CNT_W'(PULSE_CYC - 1) :
      (state_next == BC_ACCESS) ? CNT_W'(ACCESS_CYC - 1) : CNT_W'(HOLD_CYC - 1);

   // State, counter and latched cycle kind
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= BC_IDLE;
         cnt_reg   <= '0;
         write_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= (state_next != state_reg) ? load_val : cnt_reg - 1'b1;
         if (state_reg == BC_IDLE) write_reg <= write_in;
      end
   end

   // Pins: select falls at setup, strobe rises before select
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ce_n_out    <= 1'b1;
         we_n_out    <= 1'b1;
         oe_n_out    <= 1'b1;
         dq_oe_n_out <= 1'b1;
         addr_out    <= '0;
         dq_out      <= '0;
         done_out    <= 1'b0;
         rdata_out   <= '0;
      end else begin
         done_out <= (state_reg == BC_HOLD) && cnt_done;
         if (state_reg == BC_IDLE && start_in) begin
            addr_out    <= addr_in;
            dq_out      <= wdata_in;
            dq_oe_n_out <= ~write_in;
            ce_n_out    <= 1'b0;
         end
         we_n_out <= ~(state_next == BC_PULSE);
         oe_n_out <= ~(state_next == BC_ACCESS);
         if (state_reg == BC_ACCESS && cnt_done) rdata_out <= dq_sync_in;
         if (state_next == BC_IDLE) begin
            ce_n_out    <= 1'b1;
            dq_oe_n_out <= 1'b1;
         end
      end
   end
endmodule : flash_bus_cycle

// ===== hw/flash_cmd_host.sv
/*
 * Host-side command sequencer for an asynchronous parallel NOR flash.
 * Turns one operation request into its unlock and command write cycles and any read cycle.
 * Requests are taken only while req_ready_out is high, one at a time.
 * The time-limit flag follows bit 5 of each read and clears on a reset op.
 * Assumes the flash pins are outside the clock domain; read data is synchronised.
 */
`timescale 1ns/1ps
module flash_cmd_host (
   input  wire logic                                   clk_in,
   input  wire logic                                   reset_in,
   input  wire logic                                   req_valid_in,
   input  wire logic [3:0]                             req_op_in,
   input  wire logic [flash_cmd_pkg::ADDR_W-1:0]       req_addr_in,
   input  wire logic [flash_cmd_pkg::DATA_W-1:0]       req_data_in,
   input  wire logic                                   byte_mode_in,
   output logic                                        req_ready_out,
   output logic                                        resp_valid_out,
   output logic [flash_cmd_pkg::DATA_W-1:0]            resp_data_out,
   output logic                                        time_limit_out,
   output logic [flash_cmd_pkg::ADDR_W-1:0]            flash_addr_out,
   output logic [flash_cmd_pkg::DATA_W-1:0]            flash_dq_out,
   input  wire logic [flash_cmd_pkg::DATA_W-1:0]       flash_dq_in,
   output logic                                        flash_dq_oe_n_out,
   output logic                                        flash_ce_n_out,
   output logic                                        flash_we_n_out,
   output logic                                        flash_oe_n_out
);
   import flash_cmd_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT  = 2'b10,
      ST_DONE  = 2'b11
   } host_state_e;

   host_state_e                state_reg, state_next;
   // Latched request
   logic [3:0]                 op_reg;
   logic [ADDR_W-1:0]          addr_reg;
   logic [DATA_W-1:0]          data_reg;
   logic                       byte_reg;
   logic [2:0]                 step_reg;
   // Pin synchroniser pair
   logic [DATA_W-1:0]          dq_meta_reg;
   logic [DATA_W-1:0]          dq_sync_reg;
   // Pin cycle engine results
   logic                       cyc_done;
   logic [DATA_W-1:0]          cyc_rdata;

   // ******************************
   // Pin input synchroniser
   // ******************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         dq_meta_reg <= '0;
         dq_sync_reg <= '0;
      end else begin
         dq_meta_reg <= flash_dq_in;
         dq_sync_reg <= dq_meta_reg;
      end
   end

   // ******************************
   // Sequence tables
   // ******************************
   // Unlock addresses follow the width select latched with the request
   wire [ADDR_W-1:0] unl1 = byte_reg ? UNLOCK1_BYTE : UNLOCK1_WORD;
   wire [ADDR_W-1:0] unl2 = byte_reg ? UNLOCK2_BYTE : UNLOCK2_WORD;
   wire              is_erase = (op_reg == OP_CHIP_ERASE) || (op_reg == OP_BLOCK_ERASE) ||
                                (op_reg == OP_SECTOR_ERASE);
   wire              single = (op_reg == OP_READ) || (op_reg == OP_RESET) ||
                              (op_reg == OP_SUSPEND) || (op_reg == OP_RESUME);
   wire [2:0]        last_step = single ? 3'h0 : is_erase ? 3'h5 :
                                 (op_reg == OP_PROGRAM) ? 3'h3 : 3'h2;

   // Command byte of the third cycle
   wire [DATA_W-1:0] third_dat = (op_reg == OP_PROGRAM) ? DAT_PROGRAM :
                                 is_erase ? DAT_ERASE_SETUP : DAT_AUTOSEL;
   // Final erase command and its address
   wire [DATA_W-1:0] erase_dat = (op_reg == OP_CHIP_ERASE)  ? DAT_CHIP_ERASE :
                                 (op_reg == OP_BLOCK_ERASE) ? DAT_BLOCK_ERASE :
                                 DAT_SECTOR_ERASE;
   wire [ADDR_W-1:0] erase_adr = (op_reg == OP_CHIP_ERASE) ? unl1 : addr_reg;
   // Lone command values
   wire [DATA_W-1:0] lone_dat = (op_reg == OP_RESET)   ? DAT_RESET :
                                (op_reg == OP_SUSPEND) ? DAT_SUSPEND :
                                DAT_RESUME;

   // Address and data of the current cycle
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;
   always_comb begin
      cyc_addr = unl1;
      cyc_data = DAT_UNLOCK1;
      if (single) begin
         cyc_addr = addr_reg;
         cyc_data = lone_dat;
      end else begin
         unique case (step_reg)
            3'h0: begin
               cyc_addr = unl1;
               cyc_data = DAT_UNLOCK1;
            end
            3'h1: begin
               cyc_addr = unl2;
               cyc_data = DAT_UNLOCK2;
            end
            3'h2: begin
               cyc_addr = unl1;
               cyc_data = third_dat;
            end
            3'h3: begin
               cyc_addr = is_erase ? unl1 : addr_reg;
               cyc_data = is_erase ? DAT_UNLOCK1 : data_reg;
            end
            3'h4: begin
               cyc_addr = unl2;
               cyc_data = DAT_UNLOCK2;
            end
            3'h5: begin
               cyc_addr = erase_adr;
               cyc_data = erase_dat;
            end
            default: begin
               cyc_addr = unl1;
               cyc_data = DAT_UNLOCK1;
            end
         endcase
      end
   end

   // Autoselect sequence ends with a read of the requested offset
   wire as_read   = (op_reg == OP_AUTOSEL) && (step_reg == 3'h3);
   wire cyc_write = (op_reg != OP_READ) && !as_read;
   wire last      = as_read || (!((op_reg == OP_AUTOSEL)) && step_reg == last_step);

   // Handshake events; a request is refused until ready is shown
   wire take_req  = (state_reg == ST_IDLE) && req_valid_in && req_ready_out;
   wire cyc_end   = (state_reg == ST_WAIT) && cyc_done;
   wire issue_now = (state_reg == ST_ISSUE);

   // ******************************
   // Request sequencing
   // ******************************
   // One pin cycle per step, response after the last
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:  if (take_req) state_next = ST_ISSUE;
         ST_ISSUE: state_next = ST_WAIT;
         ST_WAIT:  if (cyc_done) state_next = last ? ST_DONE : ST_ISSUE;
         ST_DONE:  state_next = ST_IDLE;
      endcase
   end

   // Request capture and step advance
   // Autoselect goes from its third write straight to its read
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= ST_IDLE;
         op_reg    <= OP_READ;
         addr_reg  <= '0;
         data_reg  <= '0;
         byte_reg  <= 1'b0;
         step_reg  <= '0;
      end else begin
         state_reg <= state_next;
         if (take_req) begin
            op_reg   <= req_op_in;
            addr_reg <= req_addr_in;
            data_reg <= req_data_in;
            byte_reg <= byte_mode_in;
            step_reg <= '0;
         end else if (cyc_end && (op_reg == OP_AUTOSEL) && step_reg == 3'h2)
            step_reg <= 3'h3;
         else if (cyc_end)
            step_reg <= step_reg + 3'h1;
      end
   end

   // Handshake outputs; time-limit flag seen on any read
   // Ready is registered from the next state, so it mirrors the idle state in the same cycle
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         req_ready_out  <= 1'b0;
         resp_valid_out <= 1'b0;
         resp_data_out  <= '0;
         time_limit_out <= 1'b0;
      end else begin
         req_ready_out  <= (state_next == ST_IDLE);
         resp_valid_out <= (state_reg == ST_DONE);
         if (cyc_end && last)
            resp_data_out <= cyc_rdata;
         if (cyc_end && !cyc_write)
            time_limit_out <= cyc_rdata[TIME_LIMIT_BIT];
         else if (cyc_end && op_reg == OP_RESET)
            time_limit_out <= 1'b0;
      end
   end

   // ******************************
   // Pin cycle engine
   // ******************************
   flash_bus_cycle u_cycle (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .start_in    (issue_now),
      .write_in    (cyc_write),
      .addr_in     (cyc_addr),
      .wdata_in    (cyc_data),
      .dq_sync_in  (dq_sync_reg),
      .done_out    (cyc_done),
      .rdata_out   (cyc_rdata),
      .addr_out    (flash_addr_out),
      .dq_out      (flash_dq_out),
      .dq_oe_n_out (flash_dq_oe_n_out),
      .ce_n_out    (flash_ce_n_out),
      .we_n_out    (flash_we_n_out),
      .oe_n_out    (flash_oe_n_out)
   );
endmodule : flash_cmd_host

// ===== dv/flash_cmd_host_asserts.sv
/* Pin and handshake assertions for flash_cmd_host.
   Assumes a bind from the testbench top onto the host's ports. */
`timescale 1ns/1ps
module flash_cmd_host_asserts (
   input wire logic                              clk_in,
   input wire logic                              reset_in,
   input wire logic                              byte_mode_in,
   input wire logic                              req_ready_out,
   input wire logic                              resp_valid_out,
   input wire logic [flash_cmd_pkg::ADDR_W-1:0]  flash_addr_out,
   input wire logic [flash_cmd_pkg::DATA_W-1:0]  flash_dq_out,
   input wire logic                              flash_dq_oe_n_out,
   input wire logic                              flash_ce_n_out,
   input wire logic                              flash_we_n_out,
   input wire logic                              flash_oe_n_out
);
   import flash_cmd_pkg::*;
   // ****************
   // Bus cycle and handshake rules
   // ****************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   a_write_form: assert property (
      !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out && !flash_dq_oe_n_out) else $error("bad write form");
   a_read_float: assert property (
      !flash_oe_n_out |-> flash_dq_oe_n_out && flash_we_n_out) else $error("drive during read");
   a_write_stable: assert property (
      !flash_we_n_out |-> $stable(flash_addr_out) && $stable(flash_dq_out)) else $error("write moved");
   a_pulse_len: assert property (
      $fell(flash_we_n_out) |-> !flash_we_n_out [*5]) else $error("write pulse short");
   a_unlock_one: assert property (
      !flash_we_n_out && flash_dq_out == DAT_UNLOCK1 |->
      flash_addr_out == (byte_mode_in ? UNLOCK1_BYTE : UNLOCK1_WORD)) else $error("first unlock address");
   a_unlock_two: assert property (
      !flash_we_n_out && flash_dq_out == DAT_UNLOCK2 |->
      flash_addr_out == (byte_mode_in ? UNLOCK2_BYTE : UNLOCK2_WORD)) else $error("second unlock address");
   a_resp_pulse: assert property (
      resp_valid_out |-> req_ready_out ##1 !resp_valid_out) else $error("response handshake");
   a_idle_quiet: assert property (
      req_ready_out |-> flash_ce_n_out && flash_we_n_out && flash_oe_n_out) else $error("pins busy when idle");
   a_reset_pins: assert property (
      $fell(reset_in) |-> flash_ce_n_out && flash_we_n_out && flash_dq_oe_n_out) else $error("pins after reset");
   c_byte_write: cover property (!flash_we_n_out && byte_mode_in);
   c_read: cover property (!flash_oe_n_out);
   c_resp: cover property (resp_valid_out);
endmodule : flash_cmd_host_asserts

// ===== dv/flash_model.sv
/* Behavioural parallel NOR flash: command decoding, autoselect, erase.
   Assumes the testbench resolves the shared data wire. */
`timescale 1ns/1ps
module flash_model #(
   parameter logic [15:0] MAKER_CODE = 16'h00c5, // Arbitrary value
   parameter logic [15:0] CONT_CODE  = 16'h0033, // Arbitrary value
   parameter logic [15:0] DEV_CODE   = 16'h2a5c, // Arbitrary value
   parameter logic [20:0] FAIL_ADDR  = 21'h000077,
   parameter int          ERASE_NS   = 20000
) (
   input  wire logic [flash_cmd_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [flash_cmd_pkg::DATA_W-1:0] dq_in,
   input  wire logic                             ce_n_in,
   input  wire logic                             we_n_in,
   input  wire logic                             oe_n_in,
   input  wire logic                             byte_mode_in,
   output logic      [flash_cmd_pkg::DATA_W-1:0] dq_out
);
   import flash_cmd_pkg::*;
   // ****************
   // Command decoder
   // ****************
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] last = 16'h0000;
   logic [ADDR_W-1:0] a_lat, ebase, emask;
   int st = 0;
   bit asel, busy, susp, tlim, wr_on;
   time t0;
   wire [ADDR_W-1:0] u1 = byte_mode_in ? UNLOCK1_BYTE : UNLOCK1_WORD;
   wire [ADDR_W-1:0] u2 = byte_mode_in ? UNLOCK2_BYTE : UNLOCK2_WORD;
   // Finish an erase whose time has run out
   function automatic void settle();
      int q[$];
      if (busy && !susp && $time - t0 >= ERASE_NS) begin
         foreach (mem[k]) if (((21'(k) ^ ebase) & emask) == 21'h0) q.push_back(k);
         foreach (q[i]) mem.delete(q[i]);
         busy = 0;
      end
   endfunction : settle
   function automatic void erase(logic [20:0] m);
      emask = m;
      ebase = a_lat;
      busy = 1;
      t0 = $time;
   endfunction : erase
   task automatic cmd(input logic [15:0] d);
      settle();
      if (busy && !susp) begin
         if (d == DAT_SUSPEND) susp = 1;
      end else if (tlim) begin
         if (d == DAT_RESET) tlim = 0;
      end else if (d == DAT_RESET && st != 3) begin
         st = 0;
         asel = 0;
      end else if (susp && st == 0 && d == DAT_RESUME) begin
         susp = 0;
         t0 = $time;
      end else begin
         case (st)
            0, 4: st = (a_lat == u1 && d == DAT_UNLOCK1) ? st + 1 : 0;
            1, 5: st = (a_lat == u2 && d == DAT_UNLOCK2) ? st + 1 : 0;
            2: begin
               if (a_lat == u1 && d == DAT_AUTOSEL) asel = 1;
               st = a_lat != u1 ? 0 : d == DAT_PROGRAM ? 3 : (d == DAT_ERASE_SETUP && !susp) ? 4 : 0;
            end
            3: begin
               if (a_lat == FAIL_ADDR) tlim = 1;
               else mem[a_lat] = d;
               st = 0;
            end
            default: begin
               st = 0;
               if (a_lat == u1 && d == DAT_CHIP_ERASE) erase(21'h0);
               if (d == DAT_BLOCK_ERASE) erase(21'h0f8000);
               if (d == DAT_SECTOR_ERASE) erase(21'h0ff800);
            end
         endcase
      end
   endtask : cmd
   // Address on the later fall, data on the earlier rise
   always @(negedge ce_n_in or negedge we_n_in) if (!ce_n_in && !we_n_in && oe_n_in) begin
      a_lat = addr_in;
      wr_on = 1;
   end
   always @(posedge ce_n_in or posedge we_n_in) if (wr_on) begin
      wr_on = 0;
      cmd(dq_in);
   end
   function automatic logic [15:0] rd(logic [20:0] a);
      settle();
      if (tlim) return 16'h0020;
      if (busy && (!susp || ((a ^ ebase) & emask) == 21'h0)) return 16'h0000;
      if (asel) begin
         if (a == AS_CONT) return CONT_CODE;
         if (a[7:0] == (byte_mode_in ? AS_DEV_BYTE[7:0] : AS_DEV_WORD[7:0])) return DEV_CODE;
         if (a[7:0] == (byte_mode_in ? AS_PROT_BYTE[7:0] : AS_PROT_WORD[7:0])) return {15'h0, a[19:15] == 5'h01};
         if (a[7:0] == 8'h00) return MAKER_CODE;
      end
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction : rd
   // Drive when selected for reading, else show the inverse
   always @(ce_n_in, oe_n_in, addr_in) begin
      if (!ce_n_in && !oe_n_in) last = rd(addr_in);
      dq_out = (!ce_n_in && !oe_n_in) ? last : ~last;
   end
endmodule : flash_model

// ===== dv/tb_flash_cmd_host.sv
/* Self-checking bench for flash_cmd_host with a behavioural flash.
   Assumes the model and checker are compiled first. */
`timescale 1ns/1ps
module tb_flash_cmd_host;
   import flash_cmd_pkg::*;
   // ****************
   // Clock, pins, instances
   // ****************
   localparam int W = 2100;
   localparam logic [15:0] MK = 16'h00c5, CN = 16'h0033, DV = 16'h2a5c;
   logic clk_in = 0, reset_in = 1, req_valid_in = 0, byte_mode_in = 0;
   logic [3:0] req_op_in = 4'h0;
   logic [ADDR_W-1:0] req_addr_in = 0, flash_addr_out;
   logic [DATA_W-1:0] req_data_in = 0, resp_data_out, flash_dq_out, flash_dq_in, model_dq;
   logic req_ready_out, resp_valid_out, time_limit_out;
   logic flash_dq_oe_n_out, flash_ce_n_out, flash_we_n_out, flash_oe_n_out;
   int failures = 0, total_checks = 0, cycles = 0;
   always #5 clk_in = ~clk_in;
   assign flash_dq_in = !flash_dq_oe_n_out ? flash_dq_out : model_dq;
   flash_cmd_host u_dut (.clk_in, .reset_in, .req_valid_in, .req_op_in, .req_addr_in, .req_data_in,
      .byte_mode_in, .req_ready_out, .resp_valid_out, .resp_data_out, .time_limit_out, .flash_addr_out,
      .flash_dq_out, .flash_dq_in, .flash_dq_oe_n_out, .flash_ce_n_out, .flash_we_n_out, .flash_oe_n_out);
   flash_model #(.MAKER_CODE(MK), .CONT_CODE(CN), .DEV_CODE(DV), .FAIL_ADDR(21'h000077), .ERASE_NS(20000))
      u_flash (.addr_in(flash_addr_out), .dq_in(flash_dq_in), .ce_n_in(flash_ce_n_out),
      .we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out), .byte_mode_in, .dq_out(model_dq));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // One request once ready is seen, held for one cycle, then wait for the response
   task automatic op(input logic [3:0] o, input logic [20:0] a, input logic [15:0] d = 16'h0);
      int n;
      int m;
      n = 0;
      m = 0;
      do begin
         @(posedge clk_in);
         #1 n++;
      end while (req_ready_out !== 1'b1 && n < 50);
      req_valid_in = 1;
      req_op_in = o;
      req_addr_in = a;
      req_data_in = d;
      @(posedge clk_in);
      #1 req_valid_in = 0;
      do begin
         @(posedge clk_in);
         #1 m++;
      end while (resp_valid_out !== 1'b1 && m < 400);
      if (req_ready_out === 1'bx || n >= 50 || m >= 400) check(16'h0, 16'h1);
   endtask : op
   task automatic rd_chk(input logic [20:0] a, input logic [15:0] e);
      op(OP_READ, a);
      check(resp_data_out, e);
   endtask : rd_chk
   task automatic t_program();
      rd_chk(21'h000005, 16'hffff);
      op(OP_PROGRAM, 21'h000005, 16'h1234);
      rd_chk(21'h000005, 16'h1234);
      byte_mode_in = 1;
      op(OP_PROGRAM, 21'h000009, 16'h5a5a);
      rd_chk(21'h000009, 16'h5a5a);
      byte_mode_in = 0;
   endtask : t_program
   task automatic t_autosel();
      for (int bm = 0; bm < 2; bm++) begin
         byte_mode_in = bm[0];
         op(OP_AUTOSEL, AS_MAKER);
         check(resp_data_out, MK);
         rd_chk(AS_CONT, CN);
         rd_chk(bm ? AS_DEV_BYTE : AS_DEV_WORD, DV);
         rd_chk(21'h008000 | (bm ? AS_PROT_BYTE : AS_PROT_WORD), 16'h0001);
         rd_chk(21'h010000 | (bm ? AS_PROT_BYTE : AS_PROT_WORD), 16'h0000);
         op(OP_RESET, 21'h1fffff);
         rd_chk(21'h000005, 16'h1234);
      end
      byte_mode_in = 0;
   endtask : t_autosel
   task automatic t_timelimit();
      op(OP_PROGRAM, 21'h000077, 16'h4321);
      op(OP_READ, 21'h000009);
      check({15'h0, time_limit_out}, 16'h0001);
      op(OP_RESET, 21'h0);
      check({15'h0, time_limit_out}, 16'h0000);
      rd_chk(21'h000005, 16'h1234);
   endtask : t_timelimit
   task automatic t_erase();
      op(OP_PROGRAM, 21'h000805, 16'h0f0f);
      op(OP_PROGRAM, 21'h010003, 16'h3c3c);
      op(OP_SECTOR_ERASE, 21'h000812);
      op(OP_RESET, 21'h0);
      rd_chk(21'h000005, 16'h0000);
      op(OP_SUSPEND, 21'h001234);
      rd_chk(21'h000005, 16'h1234);
      rd_chk(21'h000805, 16'h0000);
      op(OP_RESUME, 21'h0);
      repeat (W) @(posedge clk_in);
      rd_chk(21'h000805, 16'hffff);
      rd_chk(21'h000005, 16'h1234);
      op(OP_BLOCK_ERASE, 21'h000400);
      repeat (W) @(posedge clk_in);
      rd_chk(21'h000005, 16'hffff);
      rd_chk(21'h010003, 16'h3c3c);
      op(OP_CHIP_ERASE, 21'h0);
      repeat (W) @(posedge clk_in);
      rd_chk(21'h010003, 16'hffff);
   endtask : t_erase
   // Cycle ceiling against hangs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(posedge clk_in);
      #1 reset_in = 0;
      t_program();
      t_autosel();
      t_timelimit();
      t_erase();
      end_sim();
   end
endmodule : tb_flash_cmd_host
bind flash_cmd_host flash_cmd_host_asserts u_chk (.clk_in, .reset_in, .byte_mode_in, .req_ready_out,
   .resp_valid_out, .flash_addr_out, .flash_dq_out, .flash_dq_oe_n_out, .flash_ce_n_out, .flash_we_n_out,
   .flash_oe_n_out);
